// ===== hdl/cpu_sub_cmp_logic_shift_unit.sv
/*
 * subtract, compare, logic and shift datapath of the core: one
 * operation per valid cycle, result and flags registered one cycle later.
 * assumes the decoder supplies operands, the current carry flag and the
 * condition suffix; the register file writes back on o_wr_en.
 */
// Operation
// RULE1: wide subtract of immediate, 24-bit result
// RULE2: 16-bit register subtract including carry
// RULE3: 16-bit immediate subtract including carry
// RULE4: conditional forms run on matching carry
// RULE5: 16-bit register compare sets flags
// RULE6: 16-bit compare with signed 7-bit immediate
// RULE7: 24-bit register compare sets flags
// RULE8: 24-bit compare with immediate
// RULE9: bitwise AND of registers, conditional
// RULE10: bitwise OR of registers, conditional
// RULE11: bitwise exclusive-OR of registers, conditional
// RULE12: one's complement of register or immediate
// RULE13: logic ops accept sign-extended 7-bit immediate
// RULE14: logical right shift by register count
// RULE15: arithmetic right shift, register or immediate
// RULE16: logical left shift, register or immediate
// RULE17: compares set flags, keep destination
// RULE18: logical right shift also takes immediate
module cpu_sub_cmp_logic_shift_unit
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_valid,
    input wire alu_pkg::op_t i_op,
    input wire alu_pkg::cond_t i_cond,
    input wire logic i_use_imm,
    input wire logic [alu_pkg::WIDE_W-1:0] i_src_a,
    input wire logic [alu_pkg::WIDE_W-1:0] i_src_b,
    input wire logic [alu_pkg::IMM_W-1:0] i_imm7,
    input wire logic i_carry,
    output logic [alu_pkg::WIDE_W-1:0] o_result,
    output logic o_wr_en,
    output logic o_flags_we,
    output logic o_flag_z,
    output logic o_flag_n,
    output logic o_flag_v,
    output logic o_flag_c,
    output logic o_done
);

    typedef struct packed {
        logic [alu_pkg::WIDE_W-1:0] result;
        logic wr_en;
        logic flags_we;
        logic z;
        logic n;
        logic v;
        logic c;
        logic done;
    } state_t;

    state_t st;
    state_t next_st;

    function automatic logic [alu_pkg::WORD_W-1:0] sext7(input logic [alu_pkg::IMM_W-1:0] imm);
        sext7 = {{(alu_pkg::WORD_W-alu_pkg::IMM_W){imm[alu_pkg::IMM_W-1]}}, imm};
    endfunction : sext7

    function automatic logic [alu_pkg::WIDE_W-1:0] zext7(input logic [alu_pkg::IMM_W-1:0] imm);
        zext7 = {{(alu_pkg::WIDE_W-alu_pkg::IMM_W){1'b0}}, imm};
    endfunction : zext7

    alu_shift_if sh_bus ();

    alu_barrel_shift u_shift
    (
        .sh(sh_bus)
    );

    logic exec;
    logic [alu_pkg::WORD_W-1:0] a16;
    logic [alu_pkg::WORD_W-1:0] b16;
    logic [alu_pkg::WORD_W:0] diff16;
    logic [alu_pkg::WIDE_W-1:0] b24;
    logic [alu_pkg::WIDE_W:0] diff24;
    logic [alu_pkg::IMM_W-1:0] count;

    // conditional suffix only qualifies register-register forms
    always_comb
    begin
        exec = i_valid;
        if (!i_use_imm)
        begin
            unique case (i_cond)
                alu_pkg::cond_always: exec = i_valid;
                alu_pkg::cond_if_carry_set: exec = i_valid && i_carry; // RULE4
                alu_pkg::cond_if_carry_clear: exec = i_valid && !i_carry; // RULE4
                default: exec = 1'b0;
            endcase
        end
    end

    always_comb
    begin
        a16 = i_src_a[alu_pkg::WORD_W-1:0];
        b16 = i_src_b[alu_pkg::WORD_W-1:0];
        if (i_use_imm)
        begin
            // the borrow form takes an unsigned immediate, the rest sign7
            if (i_op == alu_pkg::op_sub_borrow)
            begin
                b16 = {{(alu_pkg::WORD_W-alu_pkg::IMM_W){1'b0}}, i_imm7}; // RULE3
            end
            else
            begin
                b16 = sext7(i_imm7); // RULE6 RULE13
            end
        end
        b24 = i_use_imm ? zext7(i_imm7) : i_src_b; // RULE1 RULE8
    end

    always_comb
    begin
        if (i_op == alu_pkg::op_sub_borrow)
        begin
            diff16 = {1'b0, a16} - {1'b0, b16} - {{alu_pkg::WORD_W{1'b0}}, i_carry}; // RULE2 RULE3
        end
        else
        begin
            diff16 = {1'b0, a16} - {1'b0, b16}; // RULE5 RULE6
        end
        diff24 = {1'b0, i_src_a} - {1'b0, b24}; // RULE1 RULE7 RULE8
    end

    // counts above the word width are limited so the word empties fully, or fills with sign for op_sar
    always_comb
    begin
        count = i_use_imm ? i_imm7 : i_src_b[alu_pkg::IMM_W-1:0]; // RULE18
        sh_bus.data = a16;
        if (count > {{(alu_pkg::IMM_W-alu_pkg::CNT_W){1'b0}}, alu_pkg::CNT_MAX})
        begin
            sh_bus.amount = alu_pkg::CNT_MAX;
        end
        else
        begin
            sh_bus.amount = count[alu_pkg::CNT_W-1:0];
        end
        unique case (i_op)
            alu_pkg::op_sar: sh_bus.kind = alu_pkg::arith_right_shift; // RULE15
            alu_pkg::op_shl: sh_bus.kind = alu_pkg::left_shift_logical; // RULE16
            default: sh_bus.kind = alu_pkg::shift_right_logical; // RULE14
        endcase
    end

    always_comb
    begin
        logic [alu_pkg::WORD_W-1:0] word;
        word = '0;
        next_st = st;
        next_st.done = i_valid;
        next_st.wr_en = 1'b0;
        next_st.flags_we = 1'b0;
        if (exec)
        begin
            unique case (i_op)
                alu_pkg::op_sub_wide:
                begin
                    // address arithmetic: flags stay as they were
                    next_st.result = diff24[alu_pkg::WIDE_W-1:0]; // RULE1
                    next_st.wr_en = 1'b1;
                end
                alu_pkg::op_sub_borrow, alu_pkg::op_cmp_word:
                begin
                    word = diff16[alu_pkg::WORD_W-1:0];
                    next_st.wr_en = (i_op == alu_pkg::op_sub_borrow); // RULE17
                    if (next_st.wr_en)
                    begin
                        next_st.result = {8'h00, word}; // RULE2 RULE3
                    end
                    next_st.flags_we = 1'b1;
                    next_st.z = (word == '0); // RULE5
                    next_st.n = word[alu_pkg::WORD_W-1];
                    next_st.c = diff16[alu_pkg::WORD_W];
                    next_st.v = (a16[alu_pkg::WORD_W-1] ^ b16[alu_pkg::WORD_W-1])
                        & (a16[alu_pkg::WORD_W-1] ^ word[alu_pkg::WORD_W-1]);
                end
                alu_pkg::op_cmp_wide:
                begin
                    next_st.flags_we = 1'b1; // RULE17
                    next_st.z = (diff24[alu_pkg::WIDE_W-1:0] == '0); // RULE7 RULE8
                    next_st.n = diff24[alu_pkg::WIDE_W-1];
                    next_st.c = diff24[alu_pkg::WIDE_W];
                    next_st.v = (i_src_a[alu_pkg::WIDE_W-1] ^ b24[alu_pkg::WIDE_W-1])
                        & (i_src_a[alu_pkg::WIDE_W-1] ^ diff24[alu_pkg::WIDE_W-1]);
                end
                default:
                begin
                    unique case (i_op)
                        alu_pkg::op_and: word = a16 & b16; // RULE9 RULE13
                        alu_pkg::op_or: word = a16 | b16; // RULE10 RULE13
                        alu_pkg::op_xor: word = a16 ^ b16; // RULE11 RULE13
                        alu_pkg::op_not: word = ~b16; // RULE12
                        default: word = sh_bus.result; // RULE14 RULE15 RULE16
                    endcase
                    next_st.result = {8'h00, word};
                    next_st.wr_en = 1'b1;
                    next_st.flags_we = 1'b1;
                    next_st.z = (word == '0);
                    next_st.n = word[alu_pkg::WORD_W-1];
                    next_st.v = 1'b0;
                    next_st.c = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            st <= '{result: alu_pkg::RESULT_RST, wr_en: 1'b0, flags_we: 1'b0, z: alu_pkg::FLAG_RST,
                    n: alu_pkg::FLAG_RST, v: alu_pkg::FLAG_RST, c: alu_pkg::FLAG_RST, done: 1'b0};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign o_result = st.result;
    assign o_wr_en = st.wr_en;
    assign o_flags_we = st.flags_we;
    assign o_flag_z = st.z;
    assign o_flag_n = st.n;
    assign o_flag_v = st.v;
    assign o_flag_c = st.c;
    assign o_done = st.done;

    sub_wide_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RULE1
        i_valid && i_op == alu_pkg::op_sub_wide && i_use_imm
        |=> o_wr_en && o_result == $past(i_src_a) - zext7($past(i_imm7)))
        else $error("wide subtract result wrong");

    borrow_reg_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RULE2
        exec && i_op == alu_pkg::op_sub_borrow && !i_use_imm
        |=> o_wr_en && o_result[15:0] == 16'($past(i_src_a) - $past(i_src_b) - 24'($past(i_carry))))
        else $error("borrow subtract result wrong");

    borrow_imm_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RULE3
        i_valid && i_op == alu_pkg::op_sub_borrow && i_use_imm && i_carry
        |=> o_result[15:0] == 16'($past(i_src_a) - zext7($past(i_imm7)) - 24'h1))
        else $error("borrow immediate result wrong");

    cond_skip_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RULE4
        i_valid && !i_use_imm && ((i_cond == alu_pkg::cond_if_carry_set && !i_carry)
        || (i_cond == alu_pkg::cond_if_carry_clear && i_carry))
        |=> o_done && !o_wr_en && !o_flags_we && $stable(o_result))
        else $error("conditional form ran on wrong carry");

    cmp_keep_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RULE17
        exec && (i_op == alu_pkg::op_cmp_word || i_op == alu_pkg::op_cmp_wide)
        |=> !o_wr_en && o_flags_we && $stable(o_result))
        else $error("compare wrote destination");

    cmp_word_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RULE6
        i_valid && i_op == alu_pkg::op_cmp_word && i_use_imm
        && i_src_a[15:0] == sext7(i_imm7)
        |=> o_flag_z && !o_flag_c && !o_flag_n)
        else $error("word compare with immediate flags wrong");

    cmp_wide_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RULE7
        exec && i_op == alu_pkg::op_cmp_wide && !i_use_imm && i_src_a < i_src_b
        |=> o_flag_c && !o_flag_z)
        else $error("wide compare borrow wrong");

    and_imm_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RULE13
        i_valid && i_op == alu_pkg::op_and && i_use_imm
        |=> o_result == {8'h00, 16'($past(i_src_a)) & sext7($past(i_imm7))})
        else $error("immediate and result wrong");

    shl_one_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RULE16
        i_valid && i_op == alu_pkg::op_shl && i_use_imm && i_imm7 == 7'h01
        |=> o_result[15:0] == 16'({$past(i_src_a), 1'b0}))
        else $error("left shift by one wrong");

    sar_fill_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RULE15
        i_valid && i_op == alu_pkg::op_sar && i_use_imm && i_imm7 >= 7'h10
        |=> o_result[15:0] == {16{$past(i_src_a[15])}})
        else $error("arithmetic shift fill wrong");

    cmp_word_reg_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RULE5
        exec && i_op == alu_pkg::op_cmp_word && !i_use_imm
        |=> o_flag_z == ($past(i_src_a[15:0]) == $past(i_src_b[15:0]))
        && o_flag_c == ($past(i_src_a[15:0]) < $past(i_src_b[15:0])))
        else $error("word compare flags wrong");

    cmp_wide_imm_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RULE8
        i_valid && i_op == alu_pkg::op_cmp_wide && i_use_imm
        |=> o_flags_we && o_flag_z == ($past(i_src_a) == zext7($past(i_imm7)))
        && o_flag_c == ($past(i_src_a) < zext7($past(i_imm7))))
        else $error("wide compare with immediate flags wrong");

    and_reg_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RULE9
        exec && i_op == alu_pkg::op_and && !i_use_imm
        |=> o_wr_en && o_result[15:0] == ($past(i_src_a[15:0]) & $past(i_src_b[15:0])))
        else $error("register and result wrong");

    or_reg_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RULE10
        exec && i_op == alu_pkg::op_or && !i_use_imm
        |=> o_wr_en && o_result[15:0] == ($past(i_src_a[15:0]) | $past(i_src_b[15:0])))
        else $error("register or result wrong");

    xor_reg_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RULE11
        exec && i_op == alu_pkg::op_xor && !i_use_imm
        |=> o_wr_en && o_result[15:0] == ($past(i_src_a[15:0]) ^ $past(i_src_b[15:0])))
        else $error("register exclusive or result wrong");

    not_imm_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RULE12
        i_valid && i_op == alu_pkg::op_not && i_use_imm
        |=> o_wr_en && o_result == {8'h00, ~sext7($past(i_imm7))})
        else $error("immediate inversion result wrong");

    shr_reg_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RULE14
        exec && i_op == alu_pkg::op_shr && !i_use_imm && i_src_b[6:0] < 7'h10
        |=> o_result[15:0] == ($past(i_src_a[15:0]) >> $past(i_src_b[3:0])))
        else $error("logical right shift result wrong");

    shr_imm_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RULE18
        i_valid && i_op == alu_pkg::op_shr && i_use_imm && i_imm7 >= 7'h10
        |=> o_wr_en && o_result == 24'h000000 && o_flag_z)
        else $error("logical right shift by immediate wrong");

    sar_reg_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RULE15
        exec && i_op == alu_pkg::op_sar && !i_use_imm && i_src_b[6:0] < 7'h10
        |=> o_result[15:0] == 16'($signed($past(i_src_a[15:0])) >>> $past(i_src_b[3:0])))
        else $error("arithmetic right shift result wrong");

    shl_reg_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RULE16
        exec && i_op == alu_pkg::op_shl && !i_use_imm && i_src_b[6:0] < 7'h10
        |=> o_result[15:0] == ($past(i_src_a[15:0]) << $past(i_src_b[3:0])))
        else $error("left shift result wrong");

    wide_keep_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RULE1
        i_valid && i_op == alu_pkg::op_sub_wide
        |=> !o_flags_we && $stable({o_flag_z, o_flag_n, o_flag_v, o_flag_c}))
        else $error("wide subtract touched flags");

    borrow_flag_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RULE2
        exec && i_op == alu_pkg::op_sub_borrow && !i_use_imm
        |=> o_flag_c == (17'($past(i_src_a[15:0])) < 17'($past(i_src_b[15:0])) + 17'($past(i_carry))))
        else $error("borrow subtract carry wrong");

    done_pulse_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // RULE4
        !i_valid |=> !o_done && !o_wr_en && !o_flags_we)
        else $error("pulse without an operation");

endmodule : cpu_sub_cmp_logic_shift_unit

// ===== hdl/alu_pkg.sv
/*
 * shared widths, reset values and encodings of the subtract, compare,
 * logic and shift datapath.
 * assumes the decoder presents one operation per valid cycle.
 */
package alu_pkg;

    localparam int WORD_W = 16;
    localparam int WIDE_W = 24;
    localparam int IMM_W = 7;
    localparam int CNT_W = 5;
    localparam int STAGES = 5;
    localparam logic [CNT_W-1:0] CNT_MAX = 5'h10;
    localparam logic [WIDE_W-1:0] RESULT_RST = 24'h000000;
    localparam logic FLAG_RST = 1'h0;

    typedef enum logic [3:0] {
        op_sub_wide,
        op_sub_borrow,
        op_cmp_word,
        op_cmp_wide,
        op_and,
        op_or,
        op_xor,
        op_not,
        op_shr,
        op_sar,
        op_shl
    } op_t;

    typedef enum logic [1:0] {
        cond_always,
        cond_if_carry_set,
        cond_if_carry_clear
    } cond_t;

    typedef enum logic [1:0] {
        shift_right_logical,
        arith_right_shift,
        left_shift_logical
    } shift_kind_t;

endpackage : alu_pkg

// ===== hdl/alu_shift_if.sv
/*
 * carrier between the datapath and its barrel shifter.
 * assumes the amount has already been limited to the word width.
 */
interface alu_shift_if;
    logic [alu_pkg::WORD_W-1:0] data;
    logic [alu_pkg::CNT_W-1:0] amount;
    alu_pkg::shift_kind_t kind;
    logic [alu_pkg::WORD_W-1:0] result;

    modport user
    (
        output data,
        output amount,
        output kind,
        input result
    );

    modport shifter
    (
        input data,
        input amount,
        input kind,
        output result
    );
endinterface : alu_shift_if

// ===== hdl/alu_barrel_shift.sv
/*
 * combinational 16-bit barrel shifter: logical right, arithmetic right
 * and logical left, one stage per bit of the amount.
 * assumes an amount of 16 or less; 16 empties the word or fills sign.
 */
module alu_barrel_shift
(
    alu_shift_if.shifter sh
);

    logic [alu_pkg::WORD_W-1:0] stage [0:alu_pkg::STAGES];
    logic fill;

    assign fill = (sh.kind == alu_pkg::arith_right_shift) ? sh.data[alu_pkg::WORD_W-1] : 1'b0;
    assign stage[0] = sh.data;

    genvar g;
    generate
        for (g = 0; g < alu_pkg::STAGES; g++)
        begin : g_stage
            localparam int STEP = 1 << g;
            logic [alu_pkg::WORD_W-1:0] moved;
            always_comb
            begin
                moved = stage[g];
                for (int b = 0; b < alu_pkg::WORD_W; b++)
                begin
                    if (sh.kind == alu_pkg::left_shift_logical)
                    begin
                        moved[b] = (b >= STEP) ? stage[g][b-STEP] : 1'b0; // RULE16
                    end
                    else
                    begin
                        moved[b] = (b + STEP < alu_pkg::WORD_W) ? stage[g][b+STEP] : fill; // RULE14 RULE15
                    end
                end
            end
            assign stage[g+1] = sh.amount[g] ? moved : stage[g];
        end
    endgenerate

    assign sh.result = stage[alu_pkg::STAGES];

endmodule : alu_barrel_shift

// ===== bench/cpu_sub_cmp_logic_shift_unit_tb.sv
/*
 * self-checking bench of the subtract, compare, logic and shift datapath.
 * assumes one operation per valid cycle and outputs one cycle after the edge.
 */
module cpu_sub_cmp_logic_shift_unit_tb;
timeunit 1ns;
timeprecision 1ns;

typedef struct packed {logic [23:0] res; logic wr; logic fwe; logic z; logic n; logic v; logic c;} exp_t;

logic i_ref_clk = 1'h0;
logic i_rst_n = 1'h0;
logic i_valid = 1'h0;
alu_pkg::op_t i_op = alu_pkg::op_and;
alu_pkg::cond_t i_cond = alu_pkg::cond_always;
logic i_use_imm = 1'h0;
logic [23:0] i_src_a = 24'h000000;
logic [23:0] i_src_b = 24'h000000;
logic [6:0] i_imm7 = 7'h00;
logic i_carry = 1'h0;
logic [23:0] o_result;
logic o_wr_en, o_flags_we, o_flag_z, o_flag_n, o_flag_v, o_flag_c, o_done;
int n_mismatch = 0;
int comparisons = 0;
int cycles = 0;
int seed = 32'ha010;
exp_t e = '0;
logic [31:0] r, ra, rb;
alu_pkg::op_t rop = alu_pkg::op_and;
alu_pkg::op_t lst [7] = '{alu_pkg::op_and, alu_pkg::op_or, alu_pkg::op_xor, alu_pkg::op_not,
    alu_pkg::op_sub_borrow, alu_pkg::op_cmp_word, alu_pkg::op_cmp_wide};
int cnts [5] = '{0, 1, 15, 16, 127};

cpu_sub_cmp_logic_shift_unit dut
(
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_valid(i_valid), .i_op(i_op), .i_cond(i_cond),
    .i_use_imm(i_use_imm), .i_src_a(i_src_a), .i_src_b(i_src_b), .i_imm7(i_imm7), .i_carry(i_carry),
    .o_result(o_result), .o_wr_en(o_wr_en), .o_flags_we(o_flags_we), .o_flag_z(o_flag_z),
    .o_flag_n(o_flag_n), .o_flag_v(o_flag_v), .o_flag_c(o_flag_c), .o_done(o_done)
);

always #25 i_ref_clk = ~i_ref_clk;

task automatic finish_test();
    if (n_mismatch == 0 && comparisons > 0)
    begin
        $display("All checks passed");
    end
    else
    begin
        $display("Checks failed");
    end
    $finish;
endtask : finish_test

// cut a hang short
always @(posedge i_ref_clk)
begin
    cycles++;
    if (cycles >= 5000)
    begin
        n_mismatch++;
        finish_test();
    end
end

task automatic check(input logic [23:0] seen, input logic [23:0] want);
    comparisons++;
    if (seen !== want)
    begin
        n_mismatch++;
        $display("ERROR t=%0t seen=%h expected=%h", $time, seen, want);
    end
endtask : check

function automatic exp_t model(alu_pkg::op_t op, alu_pkg::cond_t cd, logic ui, logic [23:0] a,
    logic [23:0] b, logic [6:0] im, logic cy, exp_t prev);
    exp_t m;
    logic [16:0] d16;
    logic [24:0] d24;
    logic [15:0] b16, r16, s7;
    logic [23:0] b24;
    int cnt;
    m = prev;
    m.wr = 1'h0;
    m.fwe = 1'h0;
    s7 = {{9{im[6]}}, im};
    // register forms skipped on a carry mismatch or the never code
    if (!ui && (cd == alu_pkg::cond_if_carry_set ? !cy : cd == alu_pkg::cond_if_carry_clear ? cy :
        cd != alu_pkg::cond_always))
        return m;
    r16 = 16'h0000;
    cnt = ui ? int'(im) : int'(b[6:0]);
    b16 = ui ? s7 : b[15:0];
    case (op)
        alu_pkg::op_sub_wide:
        begin
            m.res = a - {17'h00000, im};
            m.wr = 1'h1;
            return m;
        end
        alu_pkg::op_sub_borrow, alu_pkg::op_cmp_word:
        begin
            if (op == alu_pkg::op_sub_borrow && ui)
                b16 = {9'h000, im};
            d16 = {1'h0, a[15:0]} - {1'h0, b16} - 17'((op == alu_pkg::op_sub_borrow) & cy);
            m.c = d16[16];
            m.v = (a[15] != b16[15]) && (d16[15] != a[15]);
            m.z = d16[15:0] == 16'h0000;
            m.n = d16[15];
            m.fwe = 1'h1;
            if (op == alu_pkg::op_sub_borrow)
            begin
                m.res = {8'h00, d16[15:0]};
                m.wr = 1'h1;
            end
            return m;
        end
        alu_pkg::op_cmp_wide:
        begin
            b24 = ui ? {17'h00000, im} : b;
            d24 = {1'h0, a} - {1'h0, b24};
            m.c = d24[24];
            m.v = (a[23] != b24[23]) && (d24[23] != a[23]);
            m.z = d24[23:0] == 24'h000000;
            m.n = d24[23];
            m.fwe = 1'h1;
            return m;
        end
        alu_pkg::op_and: r16 = a[15:0] & b16;
        alu_pkg::op_or: r16 = a[15:0] | b16;
        alu_pkg::op_xor: r16 = a[15:0] ^ b16;
        alu_pkg::op_not: r16 = ~b16;
        alu_pkg::op_shr: r16 = cnt >= 16 ? 16'h0000 : a[15:0] >> cnt;
        alu_pkg::op_sar: r16 = 16'($signed(a[15:0]) >>> (cnt >= 16 ? 15 : cnt));
        alu_pkg::op_shl: r16 = cnt >= 16 ? 16'h0000 : a[15:0] << cnt;
        default: return m;
    endcase
    m.res = {8'h00, r16};
    m.wr = 1'h1;
    m.fwe = 1'h1;
    m.z = r16 == 16'h0000;
    m.n = r16[15];
    m.v = 1'h0;
    m.c = 1'h0;
    return m;
endfunction : model

task automatic step(input logic v, input alu_pkg::op_t op, input alu_pkg::cond_t cd, input logic ui,
    input logic [23:0] a, input logic [23:0] b, input logic [6:0] im, input logic cy);
    i_valid = v;
    i_op = op;
    i_cond = cd;
    i_use_imm = ui;
    i_src_a = a;
    i_src_b = b;
    i_imm7 = im;
    i_carry = cy;
    if (v)
        e = model(op, cd, ui, a, b, im, cy, e);
    else
        {e.wr, e.fwe} = 2'h0;
    @(negedge i_ref_clk);
    check(24'({o_wr_en, o_flags_we, o_done}), 24'({e.wr, e.fwe, v}));
    check(24'({o_flag_z, o_flag_n, o_flag_v, o_flag_c}), 24'({e.z, e.n, e.v, e.c}));
    case (op)
        alu_pkg::op_sub_wide: check(o_result, e.res);
        alu_pkg::op_sub_borrow: check(o_result, e.res);
        alu_pkg::op_cmp_word: check(o_result, e.res);
        alu_pkg::op_cmp_wide: check(o_result, e.res);
        alu_pkg::op_and: check(o_result, e.res);
        alu_pkg::op_or: check(o_result, e.res);
        alu_pkg::op_xor: check(o_result, e.res);
        alu_pkg::op_not: check(o_result, e.res);
        alu_pkg::op_shr: check(o_result, e.res);
        alu_pkg::op_sar: check(o_result, e.res);
        default: check(o_result, e.res);
    endcase
endtask : step

initial
begin
    repeat (3) @(negedge i_ref_clk);
    i_rst_n = 1'h1;
    step(1'h1, alu_pkg::op_sub_borrow, alu_pkg::cond_always, 1'h0, 24'h5, 24'h3, 7'h00, 1'h1);
    step(1'h1, alu_pkg::op_cmp_word, alu_pkg::cond_always, 1'h0, 24'h3, 24'h5, 7'h00, 1'h0);
    step(1'h1, alu_pkg::op_cmp_word, alu_pkg::cond_always, 1'h1, 24'h0, 24'h0, 7'h40, 1'h0);
    step(1'h1, alu_pkg::op_cmp_word, alu_pkg::cond_always, 1'h1, 24'h00ffc0, 24'h0, 7'h40, 1'h0);
    step(1'h1, alu_pkg::op_sub_wide, alu_pkg::cond_always, 1'h1, 24'h3, 24'h0, 7'h7f, 1'h0);
    step(1'h1, alu_pkg::op_cmp_wide, alu_pkg::cond_always, 1'h0, 24'h800000, 24'h1, 7'h00, 1'h0);
    // every conditional code against both carry values
    for (int k = 0; k < 56; k++)
        step(1'h1, lst[k / 8], alu_pkg::cond_t'(2'(k / 2 % 4)), 1'h0, 24'h00a5f0 + 24'(k),
            24'h0033cc, 7'h00, 1'(k % 2));
    // shift counts at the word boundary, register and immediate
    for (int k = 0; k < 30; k++)
        step(1'h1, alu_pkg::op_t'(4'(8 + k % 3)), alu_pkg::cond_always, 1'(k / 15), 24'h009a5c,
            24'(cnts[k / 3 % 5]), 7'(cnts[k / 3 % 5]), 1'h0);
    for (int k = 0; k < 800; k++)
    begin
        r = $random(seed);
        ra = $random(seed);
        rb = $random(seed);
        rop = alu_pkg::op_t'(4'(r[7:0] % 11));
        step(r[11:9] != 3'h0, rop, alu_pkg::cond_t'(r[13:12]), rop == alu_pkg::op_sub_wide || r[8],
            ra[23:0], k % 5 == 0 ? 24'(r[20:16]) : rb[23:0], r[30:24], r[31]);
        if (k == 400)
        begin
            // reset in mid-run with an operation present
            i_rst_n = 1'h0;
            i_valid = 1'h1;
            e = '0;
            @(negedge i_ref_clk);
            check(o_result, alu_pkg::RESULT_RST);
            check(24'({o_wr_en, o_flags_we, o_done, o_flag_z, o_flag_n, o_flag_v, o_flag_c}), 24'h0);
            i_rst_n = 1'h1;
        end
    end
    finish_test();
end

endmodule : cpu_sub_cmp_logic_shift_unit_tb
